// ### core/rss_irq_arb.v
// Purpose: interrupt latch and fixed-priority arbitration
// Assumes: request 0 has the highest priority
// Notes: a latched choice holds until serviced or mask cleared
`timescale 1ns/10ps
module rss_irq_arb (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Requests
  input wire [7:0] irq_req,
  // CPU side
  input wire int_start,
  input wire int_serviced,
  input wire cpu_mask_bit,
  // Result
  output reg locked_q,
  output reg [2:0] sel_q,
  output wire accept,
  output wire any_pending
);
`include "rss_map.vh"

  reg [7:0] pend_q;
  reg mask_q;
  reg [2:0] win;
  reg found;
  integer i;

  // ****************************************
  // Arbitration
  // ****************************************
  always @* begin
    win = 3'h0;
    found = 1'b0;
    for (i = `RSS_IRQ_COUNT - 1; i >= 0; i = i - 1) begin
      if (pend_q[i]) begin
        win = i[2:0];
        found = 1'b1;
      end
    end
  end

  assign any_pending = found;
  assign accept = int_start & found & ~locked_q & ~cpu_mask_bit;

  // ****************************************
  // Latch
  // ****************************************
  always @(posedge sys_clk) begin
    if (reset) begin
      pend_q <= 8'h00;
      locked_q <= 1'b0;
      sel_q <= 3'h0;
      mask_q <= 1'b0;
    end else begin
      mask_q <= cpu_mask_bit;
      pend_q <= pend_q | irq_req;
      if (accept) begin
        locked_q <= 1'b1;
        sel_q <= win;
      end else if (locked_q && int_serviced) begin
        locked_q <= 1'b0;
        pend_q <= (pend_q & ~(8'h01 << sel_q)) | irq_req;
      end else if (locked_q && mask_q && !cpu_mask_bit) begin
        locked_q <= 1'b0;
      end
    end
  end
endmodule // rss_irq_arb

// ### core/rss_map.vh
// Purpose: constants for the reset source and stage counter block
// Assumes: included by bare name from core design files
// Notes: offsets are byte addresses on the 16-bit register port
`ifndef RSS_MAP_VH
`define RSS_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define RSS_CAUSE_ADDR 16'hFE01
`define RSS_OPTION_ADDR 16'hFE1F
`define RSS_SERVICE_ADDR 16'hFFFF
// ****************************************
// Reset cause register fields
// ****************************************
`define RSS_CAUSE_POR 7
`define RSS_CAUSE_WDOG 5
`define RSS_CAUSE_ILLOP 4
`define RSS_CAUSE_ILLAD 3
`define RSS_CAUSE_FMON 2
`define RSS_CAUSE_LV 1
`define RSS_CAUSE_POR_VAL 8'h80
// ****************************************
// Option register one fields
// ****************************************
`define RSS_OPT_HALT_EN 1
`define RSS_OPT_LV_RST_DIS 4
`define RSS_OPT_LV_PWR_DN 5
`define RSS_OPT_SHORT_REC 7
`define RSS_OPT_RESET 8'h00
// ****************************************
// Stage counter and timing
// ****************************************
`define RSS_STAGE_BITS 12
`define RSS_SERVICE_CLR_MASK 12'h00F
`define RSS_LONG_END 12'hFFF
`define RSS_TAIL_END 12'h03F
`define RSS_SHORT_END 12'h01F
`define RSS_WDOG_BITS 6
`define RSS_WDOG_MAX 6'h3F
// ****************************************
// Addresses, vectors and data values
// ****************************************
`define RSS_RESET_VEC 16'hFFFE
`define RSS_RESET_VEC_LO 16'hFFFF
`define RSS_ERASED_BYTE 8'hFF
`define RSS_UNMAP_LO 16'h2000
`define RSS_UNMAP_HI 16'hBFFF
`define RSS_INT_VEC_TOP 16'hFFFC
`define RSS_IRQ_COUNT 8
`endif

// ### core/rss_stage_ctr.v
// Purpose: 12-stage counter advanced by source clock falling edges
// Assumes: adv is a one-cycle pulse per detected falling edge
// Notes: clr_all wins over clr_upper and over adv
`timescale 1ns/10ps
module rss_stage_ctr (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Control
  input wire adv,
  input wire clr_all,
  input wire clr_upper,
  // Status
  output reg [11:0] count_q,
  output wire ovf
);
`include "rss_map.vh"

  // ****************************************
  // Counter
  // ****************************************
  // Overflow ticks watchdog
  assign ovf = adv & (count_q == `RSS_LONG_END);

  always @(posedge sys_clk) begin
    if (reset || clr_all) begin
      count_q <= 12'h000;
    end else if (clr_upper) begin
      count_q <= count_q & `RSS_SERVICE_CLR_MASK;
    end else if (adv) begin
      count_q <= count_q + 12'h001;
    end
  end
endmodule // rss_stage_ctr

// ### core/rss_top.v
// Purpose: reset sources, recovery timing, watchdog, interrupt latch
// Assumes: pins sampled through three flip-flops on sys_clk
// Notes: source clock is a pin; its falling edges pace the counter
// Operation
// - Watchdog overflow resets, sets watchdog cause
// - Service write clears watchdog, upper stages
// - Stage overflow clocks the watchdog
// - Watchdog disabled only by test gating
// - Undefined instruction sets flag and resets
// - Halt disabled means illegal opcode
// - Unmapped opcode fetch resets; data fetch not
// - Erased reset vector forces monitor reset
// - Low voltage resets unless disabled
// - Low voltage recovery: 4096 then 64
// - Twelve-stage counter on source falling edge
// - Power-on pulse initialises, enables clocks
// - Halt clears the stage counter
// - Stop exit samples short recovery select
// - Counter free-runs after recovery
// - Entry saves registers, sets mask
// - Return restores registers from stack
// - Latch and arbitrate, constant vector result
// - Latched interrupt cannot be displaced
// - Internal resets: line, clear, flag, vector
// - Power-on sets only power-on flag
`timescale 1ns/10ps
module rss_top (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Register port
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  // Pins from outside the clock domain
  input wire clock_gen_source_clock,
  input wire power_on_pulse,
  input wire low_voltage_detect,
  input wire external_interrupt_pin_test_high,
  // Mode
  input wire monitor_mode,
  // CPU instruction and fetch signals
  input wire cpu_undefined_insn,
  input wire cpu_halt_insn,
  input wire cpu_opcode_fetch,
  input wire cpu_vector_fetch,
  input wire [15:0] cpu_fetch_addr,
  input wire [7:0] cpu_read_data,
  input wire return_from_interrupt,
  // Interrupts
  input wire [7:0] irq_req,
  input wire int_start,
  input wire int_serviced,
  input wire cpu_mask_bit,
  // Outputs to the system
  output wire internal_reset_line,
  output reg clock_gen_enable,
  output reg cpu_run,
  output reg forced_monitor_reset,
  output reg [15:0] cpu_vector_addr,
  output reg [2:0] vector_select,
  output reg cpu_stack_save,
  output reg cpu_mask_set,
  output reg cpu_stack_restore
);
`include "rss_map.vh"

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_RUN = 3'd0;
  localparam [2:0] ST_HOLD = 3'd1;
  localparam [2:0] ST_LONG = 3'd2;
  localparam [2:0] ST_TAIL = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;
  localparam [2:0] ST_SREC = 3'd5;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [3:0] pin_raw;
  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;
  reg [3:0] pin_s3_q;
  reg [3:0] pin_q;
  reg src_prev_q;
  genvar g;

  assign pin_raw = {external_interrupt_pin_test_high, low_voltage_detect,
                    power_on_pulse, clock_gen_source_clock};

  // A change counts only once the later two stages agree
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (reset) begin
          pin_s1_q[g] <= 1'b0;
          pin_s2_q[g] <= 1'b0;
          pin_s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          pin_s1_q[g] <= pin_raw[g];
          pin_s2_q[g] <= pin_s1_q[g];
          pin_s3_q[g] <= pin_s2_q[g];
          if (pin_s2_q[g] == pin_s3_q[g]) begin
            pin_q[g] <= pin_s3_q[g];
          end
        end
      end
    end
  endgenerate

  wire src_clk = pin_q[0];
  wire por_lvl = pin_q[1];
  wire lv_lvl = pin_q[2];
  wire tst_lvl = pin_q[3];
  wire src_fall = src_prev_q & ~src_clk;

  // ****************************************
  // Registers and state
  // ****************************************
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] cause_q;
  reg [7:0] option_q;
  reg [5:0] wdog_q;
  reg short_q;
  reg vec_hi_ff_q;
  reg fmon_req_q;
  reg ctr_clr;
  wire [11:0] stage_cnt;
  wire stage_ovf;
  wire irq_locked;
  wire [2:0] irq_sel;
  wire irq_accept;
  wire irq_any;

  wire service_wr = bus_wr & (bus_addr == `RSS_SERVICE_ADDR);
  wire in_reset = (state_q == ST_HOLD) | (state_q == ST_LONG) |
                  (state_q == ST_TAIL);

  wire wdog_off = monitor_mode & tst_lvl;

  // ****************************************
  // Reset sources
  // ****************************************
  // Watchdog overflow
  wire src_wdog = stage_ovf & ~wdog_off & (wdog_q == `RSS_WDOG_MAX) &
                  ~in_reset;
  // Halt counts as illegal when off
  wire halt_bad = cpu_halt_insn & ~option_q[`RSS_OPT_HALT_EN];
  wire src_illop = (cpu_undefined_insn | halt_bad) & cpu_run;
  wire src_illad = cpu_opcode_fetch & cpu_run &
                   (cpu_fetch_addr >= `RSS_UNMAP_LO) &
                   (cpu_fetch_addr <= `RSS_UNMAP_HI);
  wire src_fmon = cpu_vector_fetch & cpu_run & vec_hi_ff_q &
                  (cpu_fetch_addr == `RSS_RESET_VEC_LO) &
                  (cpu_read_data == `RSS_ERASED_BYTE);
  // Low voltage gated by option bits
  wire src_lv = lv_lvl & ~option_q[`RSS_OPT_LV_PWR_DN] &
                ~option_q[`RSS_OPT_LV_RST_DIS];
  wire src_short = src_wdog | src_illop | src_illad | src_fmon;

  // ****************************************
  // Submodules
  // ****************************************
  rss_stage_ctr u_stage (
    .sys_clk(sys_clk),
    .reset(reset),
    .adv(src_fall),
    .clr_all(ctr_clr),
    .clr_upper(service_wr),
    .count_q(stage_cnt),
    .ovf(stage_ovf)
  );

  rss_irq_arb u_irq (
    .sys_clk(sys_clk),
    .reset(reset),
    .irq_req(irq_req),
    .int_start(int_start),
    .int_serviced(int_serviced),
    .cpu_mask_bit(cpu_mask_bit),
    .locked_q(irq_locked),
    .sel_q(irq_sel),
    .accept(irq_accept),
    .any_pending(irq_any)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_d = state_q;
    ctr_clr = 1'b0;
    if (por_lvl || src_lv) begin
      state_d = ST_HOLD;
      ctr_clr = 1'b1;
    end else if (src_short) begin
      state_d = ST_TAIL;
      ctr_clr = 1'b1;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (cpu_halt_insn && option_q[`RSS_OPT_HALT_EN]) begin
            state_d = ST_STOP;
            ctr_clr = 1'b1;
          end
        end
        ST_HOLD: begin
          state_d = ST_LONG;
          ctr_clr = 1'b1;
        end
        ST_LONG: begin
          if (src_fall && stage_cnt == `RSS_LONG_END) begin
            state_d = ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (src_fall && stage_cnt == `RSS_TAIL_END) begin
            state_d = ST_RUN;
          end
        end
        ST_STOP: begin
          ctr_clr = 1'b1;
          if (irq_any) begin
            state_d = ST_SREC;
          end
        end
        ST_SREC: begin
          if (src_fall && stage_cnt ==
              (short_q ? `RSS_SHORT_END : `RSS_LONG_END)) begin
            state_d = ST_RUN;
          end
        end
        default: begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  assign internal_reset_line = in_reset;

  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_HOLD;
      src_prev_q <= 1'b0;
      short_q <= 1'b0;
      clock_gen_enable <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      state_q <= state_d;
      src_prev_q <= src_clk;
      if (state_q == ST_STOP && irq_any) begin
        short_q <= option_q[`RSS_OPT_SHORT_REC];
      end
      clock_gen_enable <= ~por_lvl;
      cpu_run <= (state_d == ST_RUN);
    end
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  always @(posedge sys_clk) begin
    if (reset || in_reset || service_wr) begin
      wdog_q <= 6'h00;
    end else if (stage_ovf && !wdog_off) begin
      wdog_q <= wdog_q + 6'h01;
    end
  end

  // ****************************************
  // Reset cause and monitor entry
  // ****************************************
  always @(posedge sys_clk) begin
    if (reset) begin
      cause_q <= `RSS_CAUSE_POR_VAL;
      vec_hi_ff_q <= 1'b0;
      fmon_req_q <= 1'b0;
      forced_monitor_reset <= 1'b0;
    end else begin
      if (por_lvl) begin
        cause_q <= `RSS_CAUSE_POR_VAL;
      end else begin
        if (src_wdog) begin
          cause_q[`RSS_CAUSE_WDOG] <= 1'b1;
        end
        if (src_illop) begin
          cause_q[`RSS_CAUSE_ILLOP] <= 1'b1;
        end
        if (src_illad) begin
          cause_q[`RSS_CAUSE_ILLAD] <= 1'b1;
        end
        if (src_fmon) begin
          cause_q[`RSS_CAUSE_FMON] <= 1'b1;
        end
        if (src_lv) begin
          cause_q[`RSS_CAUSE_LV] <= 1'b1;
        end
      end
      if (cpu_vector_fetch && cpu_fetch_addr == `RSS_RESET_VEC) begin
        vec_hi_ff_q <= (cpu_read_data == `RSS_ERASED_BYTE);
      end
      if (por_lvl) begin
        fmon_req_q <= 1'b0;
      end else if (src_fmon) begin
        fmon_req_q <= 1'b1;
      end
      forced_monitor_reset <= fmon_req_q & ~in_reset;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge sys_clk) begin
    if (reset || por_lvl) begin
      option_q <= `RSS_OPT_RESET;
      bus_rdata <= 8'h00;
    end else begin
      if (bus_wr && bus_addr == `RSS_OPTION_ADDR) begin
        option_q <= bus_wdata;
      end
      // Unmapped reads return zero
      if (bus_rd && bus_addr == `RSS_CAUSE_ADDR) begin
        bus_rdata <= cause_q;
      end else if (bus_rd && bus_addr == `RSS_OPTION_ADDR) begin
        bus_rdata <= option_q;
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end

  // ****************************************
  // CPU exception signalling
  // ****************************************
  always @(posedge sys_clk) begin
    if (reset) begin
      cpu_vector_addr <= `RSS_RESET_VEC;
      vector_select <= 3'h0;
      cpu_stack_save <= 1'b0;
      cpu_mask_set <= 1'b0;
      cpu_stack_restore <= 1'b0;
    end else begin
      cpu_stack_save <= irq_accept;
      cpu_mask_set <= irq_accept;
      cpu_stack_restore <= return_from_interrupt & cpu_run;
      vector_select <= irq_sel;
      if (in_reset) begin
        cpu_vector_addr <= `RSS_RESET_VEC;
      end else if (irq_locked) begin
        cpu_vector_addr <= `RSS_INT_VEC_TOP -
                           {12'h000, irq_sel, 1'b0};
      end
    end
  end
endmodule // rss_top

// ### tb/rss_cpu_model.sv
// Purpose: CPU core stand-in with free-running source clock
// Assumes: fetch is called just after a rising sys_clk edge
// Notes: erased makes both reset vector bytes read blank
`timescale 1ns/10ps
module rss_cpu_model #(
  parameter SRC_HALF = 80
) (
  // Clock and status
  input wire sys_clk,
  input wire cpu_run,
  input wire erased,
  // Source clock
  output reg clock_gen_source_clock,
  // Fetch bus
  output reg cpu_opcode_fetch,
  output reg cpu_vector_fetch,
  output reg [15:0] cpu_fetch_addr,
  output reg [7:0] cpu_read_data
);
  // ****
  // Behaviour
  // ****
  reg run_q;
  // Phase offset keeps source edges off sys_clk edges
  initial begin
    clock_gen_source_clock = 1'b0;
    #13;
    forever #SRC_HALF clock_gen_source_clock = ~clock_gen_source_clock;
  end
  task fetch(input [15:0] a, input op);
    begin
      @(posedge sys_clk);
      cpu_fetch_addr <= a;
      cpu_opcode_fetch <= op;
      @(posedge sys_clk);
      cpu_opcode_fetch <= 1'b0;
      cpu_fetch_addr <= ~a;
    end
  endtask
  initial begin
    run_q = 1'b0;
    cpu_opcode_fetch = 1'b0;
    cpu_vector_fetch = 1'b0;
    cpu_fetch_addr = 16'h0000;
    cpu_read_data = 8'h00;
    forever begin
      @(posedge sys_clk);
      if (cpu_run && !run_q) begin
        cpu_vector_fetch <= 1'b1;
        cpu_fetch_addr <= 16'hFFFE;
        cpu_read_data <= erased ? 8'hFF : 8'h3C;
        @(posedge sys_clk);
        cpu_fetch_addr <= 16'hFFFF;
        cpu_read_data <= erased ? 8'hFF : 8'hC3;
        @(posedge sys_clk);
        cpu_vector_fetch <= 1'b0;
        cpu_read_data <= ~cpu_read_data;
      end
      run_q <= cpu_run;
    end
  end
endmodule // rss_cpu_model

// ### tb/rss_top_sva.sv
// Purpose: port-level checks for rss_top
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every rss_top instance
`timescale 1ns/10ps
module rss_top_sva (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Inputs watched
  input wire [15:0] bus_addr,
  input wire bus_rd,
  input wire power_on_pulse,
  input wire cpu_undefined_insn,
  input wire cpu_opcode_fetch,
  input wire [15:0] cpu_fetch_addr,
  input wire return_from_interrupt,
  input wire int_start,
  input wire int_serviced,
  input wire cpu_mask_bit,
  // Outputs watched
  input wire [7:0] bus_rdata,
  input wire internal_reset_line,
  input wire clock_gen_enable,
  input wire cpu_run,
  input wire [15:0] cpu_vector_addr,
  input wire [2:0] vector_select,
  input wire cpu_stack_save,
  input wire cpu_mask_set,
  input wire cpu_stack_restore
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_illad;
    cpu_run && cpu_opcode_fetch &&
      cpu_fetch_addr >= 16'h2000 && cpu_fetch_addr <= 16'hBFFF;
  endsequence
  sequence s_entry;
    cpu_stack_save && cpu_mask_set;
  endsequence
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (bus_rd && bus_addr == 16'h1234 |=>
    bus_rdata == 8'h00) else $error("unmapped read not zero");
  a_undef_reset: assert property (
    cpu_run && cpu_undefined_insn |=> internal_reset_line)
    else $error("undefined instruction did not reset");
  a_illad_reset: assert property (s_illad |=> internal_reset_line)
    else $error("unmapped opcode fetch did not reset");
  a_reset_vector: assert property (
    $past(internal_reset_line) && internal_reset_line |->
    cpu_vector_addr == 16'hFFFE) else $error("reset vector wrong");
  a_run_excl: assert property (cpu_run |-> !internal_reset_line)
    else $error("running while in reset");
  a_entry_pulse: assert property (
    s_entry |-> $past(int_start) ##1 !cpu_stack_save)
    else $error("entry pulse without start or too long");
  a_save_pair: assert property (cpu_stack_save == cpu_mask_set)
    else $error("stack save and mask set apart");
  a_int_vector: assert property (cpu_stack_save |=>
    cpu_vector_addr == 16'hFFFC - {12'h000, vector_select, 1'b0})
    else $error("interrupt vector wrong");
  a_select_hold: assert property ($changed(vector_select) |->
    $past(cpu_stack_save) || $past(int_serviced) || $fell(cpu_mask_bit) ||
    internal_reset_line || $past(internal_reset_line))
    else $error("latched selection displaced");
  a_restore: assert property (
    cpu_run && return_from_interrupt |=> cpu_stack_restore)
    else $error("return did not restore");
  a_clkgen_on: assert property (
    !power_on_pulse [*8] |-> clock_gen_enable)
    else $error("clock generator not enabled");
  a_clkgen_off: assert property (
    power_on_pulse [*8] |-> !clock_gen_enable)
    else $error("clock generator on during power-on");
endmodule // rss_top_sva

bind rss_top rss_top_sva u_sva (.sys_clk, .reset, .bus_addr, .bus_rd,
  .power_on_pulse, .cpu_undefined_insn, .cpu_opcode_fetch, .cpu_fetch_addr,
  .return_from_interrupt, .int_start, .int_serviced, .cpu_mask_bit,
  .bus_rdata, .internal_reset_line, .clock_gen_enable, .cpu_run,
  .cpu_vector_addr, .vector_select, .cpu_stack_save, .cpu_mask_set,
  .cpu_stack_restore);

// ### tb/rss_top_tb.sv
// Purpose: directed bench for rss_top
// Assumes: source clock period four sys_clk cycles
// Notes: watchdog overflow too slow to reach here
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
  fails = fails + 1; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module rss_top_tb;
  // ****
  // Bench
  // ****
  reg sys_clk, reset, bus_wr, bus_rd, low_voltage_detect, erased;
  reg cpu_undefined_insn, cpu_halt_insn, return_from_interrupt;
  reg int_start, int_serviced, power_on_pulse, cpu_mask_bit;
  reg [15:0] bus_addr;
  reg [7:0] bus_wdata, irq_req, cause;
  wire [7:0] bus_rdata, cpu_read_data;
  wire [15:0] cpu_vector_addr, cpu_fetch_addr;
  wire [2:0] vector_select;
  wire internal_reset_line, clock_gen_enable, cpu_run, forced_monitor_reset;
  wire cpu_stack_save, cpu_mask_set, cpu_stack_restore;
  wire clock_gen_source_clock, cpu_opcode_fetch, cpu_vector_fetch;
  integer fails, checked, k, n;
  rss_top uut (.sys_clk, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .clock_gen_source_clock, .power_on_pulse,
    .low_voltage_detect, .external_interrupt_pin_test_high(1'b0),
    .monitor_mode(1'b0), .cpu_undefined_insn, .cpu_halt_insn,
    .cpu_opcode_fetch, .cpu_vector_fetch, .cpu_fetch_addr, .cpu_read_data,
    .return_from_interrupt, .irq_req, .int_start, .int_serviced,
    .cpu_mask_bit, .internal_reset_line, .clock_gen_enable, .cpu_run,
    .forced_monitor_reset, .cpu_vector_addr, .vector_select,
    .cpu_stack_save, .cpu_mask_set, .cpu_stack_restore);
  rss_cpu_model #(.SRC_HALF(80)) cpu (.sys_clk, .cpu_run, .erased,
    .clock_gen_source_clock, .cpu_opcode_fetch, .cpu_vector_fetch,
    .cpu_fetch_addr, .cpu_read_data);
  task results;
    begin
      if (fails == 0 && checked > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      `CHK("rdata", e, bus_rdata)
    end
  endtask
  // Codes: 0 undefined, 1 halt, 2/3 opcode/data fetch, 4 return,
  // 5 start, 6 serviced
  task hit(input integer c);
    begin
      if (c == 2 || c == 3) begin
        cpu.fetch(16'h2000, c == 2);
      end else begin
        @(posedge sys_clk);
        cpu_undefined_insn <= (c == 0);
        cpu_halt_insn <= (c == 1);
        return_from_interrupt <= (c == 4);
        int_start <= (c == 5);
        int_serviced <= (c == 6);
        @(posedge sys_clk);
        {cpu_undefined_insn, cpu_halt_insn, return_from_interrupt} <= 3'h0;
        {int_start, int_serviced} <= 2'h0;
      end
      #1;
    end
  endtask
  task wait_run(output integer w);
    begin
      w = 0;
      while (cpu_run !== 1'b1 && w < 20000) begin
        @(posedge sys_clk);
        w = w + 1;
      end
      `CHK("run", 1'h1, cpu_run)
      repeat (4) @(posedge sys_clk);
      wr(16'hFFFF, 8'hA5);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Full run is near 52000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails = fails + 1;
    results;
  end
  initial begin
    {reset, bus_wr, bus_rd, low_voltage_detect, erased} = 5'h10;
    {cpu_undefined_insn, cpu_halt_insn, return_from_interrupt} = 3'h0;
    {int_start, int_serviced} = 2'h0;
    {power_on_pulse, cpu_mask_bit} = 2'h0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    irq_req = 8'h00;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wr(16'hFFFF, 8'h5A);
    rd(16'hFE01, 8'h80);
    wr(16'hFE01, 8'hFF);
    rd(16'hFE01, 8'h80);
    rd(16'h1234, 8'h00);
    wait_run(n);
    `CHK("long", 1'h1, n > 15000)
    cause = 8'h80;
    for (k = 0; k < 3; k = k + 1) begin
      wr(16'hFE1F, 8'h00);
      hit(k);
      `CHK("internal_reset_line", 1'h1, internal_reset_line)
      `CHK("rvec", 16'hFFFE, cpu_vector_addr)
      cause = cause | ((k == 2) ? 8'h08 : 8'h10);
      wait_run(n);
      rd(16'hFE01, cause);
    end
    hit(3);
    `CHK("data fetch", 1'h0, internal_reset_line)
    for (k = 0; k < 3; k = k + 1) begin
      wr(16'hFE1F, (k == 0) ? 8'h10 : (k == 1) ? 8'h20 : 8'h00);
      @(posedge sys_clk);
      low_voltage_detect <= 1'b1;
      repeat (8) @(posedge sys_clk);
      low_voltage_detect <= 1'b0;
      #1;
      `CHK("lv internal_reset_line", k == 2, internal_reset_line)
    end
    wait_run(n);
    `CHK("lv long", 1'h1, n > 15000)
    cause = cause | 8'h02;
    rd(16'hFE01, cause);
    erased <= 1'b1;
    hit(0);
    wait_run(n);
    n = 0;
    while (internal_reset_line !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    erased <= 1'b0;
    `CHK("blank internal_reset_line", 1'h1, internal_reset_line)
    wait_run(n);
    `CHK("monitor", 1'h1, forced_monitor_reset)
    rd(16'hFE01, cause | 8'h04);
    wr(16'hFE1F, 8'h82);
    hit(1);
    `CHK("stop internal_reset_line", 1'h0, internal_reset_line)
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("stopped", 1'h0, cpu_run)
    @(posedge sys_clk);
    irq_req <= 8'h04;
    @(posedge sys_clk);
    irq_req <= 8'h00;
    wait_run(n);
    `CHK("short rec", 1'h1, n < 200)
    hit(5);
    `CHK("save", 1'h1, cpu_stack_save & cpu_mask_set)
    @(posedge sys_clk);
    #1;
    `CHK("sel", 3'h2, vector_select)
    `CHK("ivec", 16'hFFF8, cpu_vector_addr)
    @(posedge sys_clk);
    irq_req <= 8'h01;
    @(posedge sys_clk);
    irq_req <= 8'h00;
    hit(5);
    `CHK("sel held", 3'h2, vector_select)
    `CHK("no save", 1'h0, cpu_stack_save)
    hit(6);
    hit(5);
    @(posedge sys_clk);
    #1;
    `CHK("sel next", 3'h0, vector_select)
    `CHK("ivec0", 16'hFFFC, cpu_vector_addr)
    hit(4);
    `CHK("restore", 1'h1, cpu_stack_restore)
    @(posedge sys_clk);
    cpu_mask_bit <= 1'b1;
    @(posedge sys_clk);
    cpu_mask_bit <= 1'b0;
    hit(5);
    `CHK("mask release", 1'h1, cpu_stack_save)
    @(posedge sys_clk);
    power_on_pulse <= 1'b1;
    repeat (8) @(posedge sys_clk);
    power_on_pulse <= 1'b0;
    #1;
    `CHK("por gen", 1'h0, clock_gen_enable)
    `CHK("por internal_reset_line", 1'h1, internal_reset_line)
    wait_run(n);
    `CHK("por long", 1'h1, n > 15000)
    `CHK("gen on", 1'h1, clock_gen_enable)
    `CHK("no monitor", 1'h0, forced_monitor_reset)
    rd(16'hFE01, 8'h80);
    rd(16'hFE1F, 8'h00);
    results;
  end
endmodule // rss_top_tb
